// *** hdl/acsg_map.vh ***
`ifndef ACSG_MAP_VH
`define ACSG_MAP_VH
// Register offsets
`define ACSG_OFF_SETUP      8'h51
`define ACSG_OFF_FINE       8'h52
`define ACSG_OFF_LVOL       8'h53
`define ACSG_OFF_RVOL       8'h54
`define ACSG_OFF_STATUS     8'h60
// Setup register fields
`define ACSG_SETUP_LPWR     7
`define ACSG_SETUP_RPWR     6
`define ACSG_SETUP_PIN_HI   5
`define ACSG_SETUP_PIN_LO   4
`define ACSG_SETUP_LDMIC    3
`define ACSG_SETUP_RDMIC    2
`define ACSG_SETUP_SS_HI    1
`define ACSG_SETUP_SS_LO    0
// Fine gain register fields
`define ACSG_FINE_LMUTE     7
`define ACSG_FINE_LGAIN_HI  6
`define ACSG_FINE_LGAIN_LO  4
`define ACSG_FINE_RMUTE     3
`define ACSG_FINE_RGAIN_HI  2
`define ACSG_FINE_RGAIN_LO  0
// Reset values
`define ACSG_SETUP_RESET    8'h00
`define ACSG_FINE_RESET     8'h88
`define ACSG_VOL_RESET      7'h00
// Encodings
`define ACSG_PIN_GPIO       2'h0
`define ACSG_PIN_SCLK       2'h1
`define ACSG_PIN_DIN        2'h2
`define ACSG_SS_ONE         2'h0
`define ACSG_SS_TWO         2'h1
`define ACSG_SS_OFF         2'h2
`define ACSG_VOL_MIN        7'h68
`define ACSG_VOL_MAX        7'h28
`endif

// *** hdl/acsg_top.v ***
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "acsg_map.vh"

// Functional notes
// - Setup bit 7 powers the left ADC channel up; zero powers it down.
// - Setup bit 6 powers the right ADC channel up; zero powers it down.
// - Setup bits 5:4 pick mic pin: general pin, bit clock, data in.
// - Setup bit 3 feeds the left channel from the digital microphone.
// - Setup bit 2 feeds the right channel from the digital microphone.
// - Setup bits 1:0: step per word clock, per two, or none.
// - Fine bit 7 mutes the left channel; resets to muted.
// - Left fine gain 000 is 0 dB; 111 to 100 are -0.1 to -0.4 dB.
// - Fine bit 3 mutes the right channel; resets to muted.
// - Right fine gain uses the same encoding as the left.
// - Volume is seven-bit two's complement, 0.5 dB steps, -12 to +20 dB.
module acsg_top (
   // Clock, enable and reset
   input  wire       clk,
   input  wire       ce,
   input  wire       reset,
   // Register port
   input  wire [7:0] addr,
   input  wire [7:0] wdata,
   input  wire       wr,
   input  wire       rd,
   output reg  [7:0] rdata,
   // ADC word clock strobe, same clock domain
   input  wire       word_tick,
   // Channel controls
   output wire       left_power,
   output wire       right_power,
   output reg  [1:0] dmic_pin,
   output wire       left_dmic,
   output wire       right_dmic,
   output wire       left_mute,
   output wire       right_mute,
   output wire [2:0] left_fine_atten,
   output wire [2:0] right_fine_atten,
   output wire [6:0] left_vol_applied,
   output wire [6:0] right_vol_applied
);

   wire [7:0] setup;
   wire [7:0] fine;
   wire [6:0] left_vol_target;
   wire [6:0] right_vol_target;
   wire       left_ramping;
   wire       right_ramping;
   wire       jump_now;
   reg        setup_load;
   reg        fine_load;
   reg        left_load;
   reg        right_load;
   reg        tick_phase;
   reg  [7:0] next_rdata;
   reg        step_now;
   wire [1:0] ss_mode;

   assign ss_mode = setup[`ACSG_SETUP_SS_HI:`ACSG_SETUP_SS_LO];

   // Reserved codes map to the zero code (general pin, 0 dB gain) so the datapath never sees them
   function [1:0] fix_pin;
      input [1:0] code;
      begin
         fix_pin = (code == 2'h3) ? `ACSG_PIN_GPIO : code;
      end
   endfunction

   function [2:0] fix_fine;
      input [2:0] code;
      begin
         fix_fine = (code != 3'h0 && code[2] == 1'b0) ? 3'h0 : code;
      end
   endfunction

   // Write decode; unmapped addresses load nothing
   always @* begin
      setup_load = 1'b0;
      fine_load  = 1'b0;
      left_load  = 1'b0;
      right_load = 1'b0;
      if (wr) begin
         if (addr == `ACSG_OFF_SETUP) begin
            setup_load = 1'b1;
         end else if (addr == `ACSG_OFF_FINE) begin
            fine_load = 1'b1;
         end else if (addr == `ACSG_OFF_LVOL) begin
            left_load = 1'b1;
         end else if (addr == `ACSG_OFF_RVOL) begin
            right_load = 1'b1;
         end
      end
   end

   acsg_reg_byte #(
      .RESET_VAL (`ACSG_SETUP_RESET)
   ) setup_reg_inst (
      .clk       (clk),
      .ce        (ce),
      .reset     (reset),
      .load      (setup_load),
      .load_data (wdata),
      .value     (setup)
   );

   acsg_reg_byte #(
      .RESET_VAL (`ACSG_FINE_RESET)
   ) fine_reg_inst (
      .clk       (clk),
      .ce        (ce),
      .reset     (reset),
      .load      (fine_load),
      .load_data (wdata),
      .value     (fine)
   );

   // Read mux; unmapped addresses read zero
   always @* begin
      next_rdata = 8'h00;
      if (addr == `ACSG_OFF_SETUP) begin
         next_rdata = setup;
      end else if (addr == `ACSG_OFF_FINE) begin
         next_rdata = fine;
      end else if (addr == `ACSG_OFF_LVOL) begin
         next_rdata = {1'b0, left_vol_target};
      end else if (addr == `ACSG_OFF_RVOL) begin
         next_rdata = {1'b0, right_vol_target};
      end else if (addr == `ACSG_OFF_STATUS) begin
         next_rdata = {6'h00, right_ramping, left_ramping};
      end
   end

   always @(posedge clk) begin
      if (reset) begin
         rdata <= 8'h00;
      end else if (ce) begin
         rdata <= rd ? next_rdata : 8'h00;
      end
   end

   // Microphone pin choice is shared by both channels
   always @(posedge clk) begin
      if (reset) begin
         dmic_pin <= `ACSG_PIN_GPIO;
      end else if (ce) begin
         dmic_pin <= fix_pin(setup[`ACSG_SETUP_PIN_HI:
                                   `ACSG_SETUP_PIN_LO]);
      end
   end

   acsg_chan_ctrl left_ctrl_inst (
      .clk        (clk),
      .ce         (ce),
      .reset      (reset),
      .power_bit  (setup[`ACSG_SETUP_LPWR]),
      .dmic_bit   (setup[`ACSG_SETUP_LDMIC]),
      .mute_bit   (fine[`ACSG_FINE_LMUTE]),
      .atten_code (fix_fine(fine[`ACSG_FINE_LGAIN_HI:
                                 `ACSG_FINE_LGAIN_LO])),
      .power      (left_power),
      .dmic       (left_dmic),
      .mute       (left_mute),
      .atten      (left_fine_atten)
   );

   acsg_chan_ctrl right_ctrl_inst (
      .clk        (clk),
      .ce         (ce),
      .reset      (reset),
      .power_bit  (setup[`ACSG_SETUP_RPWR]),
      .dmic_bit   (setup[`ACSG_SETUP_RDMIC]),
      .mute_bit   (fine[`ACSG_FINE_RMUTE]),
      .atten_code (fix_fine(fine[`ACSG_FINE_RGAIN_HI:
                                 `ACSG_FINE_RGAIN_LO])),
      .power      (right_power),
      .dmic       (right_dmic),
      .mute       (right_mute),
      .atten      (right_fine_atten)
   );

   // Soft-step pacing in word clocks
   always @* begin
      step_now = 1'b0;
      if (word_tick) begin
         if (ss_mode == `ACSG_SS_ONE)
            step_now = 1'b1;
         else if (ss_mode == `ACSG_SS_TWO)
            step_now = tick_phase;
      end
   end

   // Free running, so a mode change needs no phase reset
   always @(posedge clk) begin
      if (reset) begin
         tick_phase <= 1'b0;
      end else if (ce && word_tick) begin
         tick_phase <= ~tick_phase;
      end
   end

   // Reserved code 11 behaves as disabled
   assign jump_now = ss_mode[1];

   acsg_vol_ramp left_ramp_inst (
      .clk       (clk),
      .ce        (ce),
      .reset     (reset),
      .load      (left_load),
      .load_code (wdata[6:0]),
      .step_en   (step_now),
      .jump      (jump_now),
      .target    (left_vol_target),
      .applied   (left_vol_applied),
      .ramping   (left_ramping)
   );

   acsg_vol_ramp right_ramp_inst (
      .clk       (clk),
      .ce        (ce),
      .reset     (reset),
      .load      (right_load),
      .load_code (wdata[6:0]),
      .step_en   (step_now),
      .jump      (jump_now),
      .target    (right_vol_target),
      .applied   (right_vol_applied),
      .ramping   (right_ramping)
   );

endmodule

// One software register; a write lands on the strobe edge
module acsg_reg_byte #(
   parameter             WIDTH     = 8,
   parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
   // Clock, enable and reset
   input  wire             clk,
   input  wire             ce,
   input  wire             reset,
   // Write side
   input  wire             load,
   input  wire [WIDTH-1:0] load_data,
   // Stored value
   output reg  [WIDTH-1:0] value
);

   always @(posedge clk) begin
      if (reset) begin
         value <= RESET_VAL;
      end else if (ce && load) begin
         value <= load_data;
      end
   end

endmodule

// Registered controls of one channel, one cycle behind the register
module acsg_chan_ctrl (
   // Clock, enable and reset
   input  wire       clk,
   input  wire       ce,
   input  wire       reset,
   // Configuration bits
   input  wire       power_bit,
   input  wire       dmic_bit,
   input  wire       mute_bit,
   input  wire [2:0] atten_code,
   // Channel controls
   output reg        power,
   output reg        dmic,
   output reg        mute,
   output reg  [2:0] atten
);

   // Reset to muted so nothing leaks out before the gain is set
   always @(posedge clk) begin
      if (reset) begin
         power <= 1'b0;
         dmic  <= 1'b0;
         mute  <= 1'b1;
         atten <= 3'h0;
      end else if (ce) begin
         power <= power_bit;
         dmic  <= dmic_bit;
         mute  <= mute_bit;
         atten <= atten_code;
      end
   end

endmodule

// Volume target of one channel and the applied value chasing it
module acsg_vol_ramp #(
   parameter             VOL_W      = 7,
   parameter [VOL_W-1:0] VOL_MIN    = `ACSG_VOL_MIN,
   parameter [VOL_W-1:0] VOL_MAX    = `ACSG_VOL_MAX,
   parameter [VOL_W-1:0] RESET_CODE = `ACSG_VOL_RESET
) (
   // Clock, enable and reset
   input  wire             clk,
   input  wire             ce,
   input  wire             reset,
   // Software write of a new target
   input  wire             load,
   input  wire [VOL_W-1:0] load_code,
   // Pacing from the shared soft-step logic
   input  wire             step_en,
   input  wire             jump,
   // Volume state
   output reg  [VOL_W-1:0] target,
   output reg  [VOL_W-1:0] applied,
   output wire             ramping
);

   // Reserved codes snap to the nearer limit of -12..+20 dB
   function [VOL_W-1:0] clamp_vol;
      input [VOL_W-1:0] code;
      begin
         if (code[VOL_W-1] && code < VOL_MIN)
            clamp_vol = VOL_MIN;
         else if (!code[VOL_W-1] && code > VOL_MAX)
            clamp_vol = VOL_MAX;
         else
            clamp_vol = code;
      end
   endfunction

   // Signed compare; one code is one 0.5 dB step
   function [VOL_W-1:0] step_toward;
      input [VOL_W-1:0] cur;
      input [VOL_W-1:0] tgt;
      begin
         if ($signed(cur) < $signed(tgt))
            step_toward = cur + {{(VOL_W-1){1'b0}}, 1'b1};
         else if ($signed(cur) > $signed(tgt))
            step_toward = cur - {{(VOL_W-1){1'b0}}, 1'b1};
         else
            step_toward = cur;
      end
   endfunction

   assign ramping = (applied != target);

   always @(posedge clk) begin
      if (reset) begin
         target <= RESET_CODE;
      end else if (ce && load) begin
         target <= clamp_vol(load_code);
      end
   end

   // A jump wins, so turning the ramp off never leaves a stale value
   always @(posedge clk) begin
      if (reset) begin
         applied <= RESET_CODE;
      end else if (ce) begin
         if (jump) begin
            applied <= target;
         end else if (step_en) begin
            applied <= step_toward(applied, target);
         end
      end
   end

endmodule

// *** testbench/acsg_top_assertions.sv ***
`timescale 1ns/1ps
module acsg_top_assertions (
   // Clock, reset and register port
   input wire       clk,
   input wire       ce,
   input wire       reset,
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire       wr,
   // Channel controls
   input wire       left_power,
   input wire       right_power,
   input wire [1:0] dmic_pin,
   input wire       left_dmic,
   input wire       right_dmic,
   input wire       left_mute,
   input wire       right_mute,
   input wire [2:0] left_fine_atten,
   input wire [2:0] right_fine_atten,
   input wire [6:0] left_vol_applied
);
   reg [1:0] step_mode;
   // Shadow of the stepping mode, needed to judge volume moves
   always @(posedge clk) begin
      if (reset)
         step_mode <= 2'h0;
      else if (ce && wr && addr == 8'h51)
         step_mode <= wdata[1:0];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Second write in a row would overtake the first
   sequence s_wr_setup;
      ce && wr && addr == 8'h51 ##1 ce && !(wr && addr == 8'h51);
   endsequence
   sequence s_wr_fine;
      ce && wr && addr == 8'h52 ##1 ce && !(wr && addr == 8'h52);
   endsequence
   a_reset_muted: assert property (disable iff (1'b0) reset && ce |=>
      left_mute && right_mute && !left_power && !right_power)
      else $error("reset state wrong");
   a_power_follow: assert property (s_wr_setup |=>
      left_power == $past(wdata[7], 2) && right_power == $past(wdata[6], 2))
      else $error("power bits do not follow");
   a_dmic_follow: assert property (s_wr_setup |=>
      left_dmic == $past(wdata[3], 2) && right_dmic == $past(wdata[2], 2)
      && (dmic_pin == $past(wdata[5:4], 2) || $past(wdata[5:4], 2) == 2'h3))
      else $error("mic selection does not follow");
   a_mute_follow: assert property (s_wr_fine |=>
      left_mute == $past(wdata[7], 2) && right_mute == $past(wdata[3], 2))
      else $error("mute bits do not follow");
   a_atten_follow: assert property (s_wr_fine |=>
      left_fine_atten == ($past(wdata[6:4], 2) inside {[3'h1:3'h3]} ?
      3'h0 : $past(wdata[6:4], 2)) && right_fine_atten ==
      ($past(wdata[2:0], 2) inside {[3'h1:3'h3]} ? 3'h0 : $past(wdata[2:0], 2)))
      else $error("attenuation does not follow");
   a_codes_legal: assert property (!(left_fine_atten inside {[3'h1:3'h3]})
      && !(right_fine_atten inside {[3'h1:3'h3]}) && dmic_pin != 2'h3)
      else $error("reserved code on output");
   a_step_single: assert property (!$past(step_mode[1]) && $changed(left_vol_applied)
      |-> 7'(left_vol_applied - $past(left_vol_applied)) inside {7'h01, 7'h7f})
      else $error("volume moved more than one step");
   a_jump_now: assert property (ce && wr && addr == 8'h53 &&
      step_mode == 2'h2 && wdata < 8'h28 ##1 ce
      |=> left_vol_applied == $past(wdata[6:0], 2))
      else $error("volume did not jump");
   a_vol_range: assert property (left_vol_applied <= 7'h28 ||
      left_vol_applied >= 7'h68) else $error("volume out of range");
endmodule

// *** testbench/acsg_top_test.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
   miscompares++; $display("unexpected %0t got %h exp %h", $time, g, e); \
   end end
module acsg_top_test;
   reg        clk = 0, ce = 1, reset = 1, wr = 0, rd = 0, word_tick = 0;
   reg  [7:0] addr = 8'h00, wdata = 8'h00;
   reg  [1:0] tc = 2'h0;
   reg  [2:0] c;
   wire [7:0] rdata;
   wire       left_power, right_power, left_dmic, right_dmic;
   wire       left_mute, right_mute;
   wire [1:0] dmic_pin;
   wire [2:0] left_fine_atten, right_fine_atten;
   wire [6:0] left_vol_applied, right_vol_applied;
   integer    miscompares = 0, comparisons = 0, n, i;
   always #10 clk = ~clk;
   // Word clock every fourth cycle
   always @(posedge clk) begin
      tc <= tc + 2'h1;
      word_tick <= (tc == 2'h3);
   end
   acsg_top acsg_top_inst (.clk, .ce, .reset, .addr, .wdata, .wr, .rd,
      .rdata, .word_tick, .left_power, .right_power, .dmic_pin, .left_dmic,
      .right_dmic, .left_mute, .right_mute, .left_fine_atten,
      .right_fine_atten, .left_vol_applied, .right_vol_applied);
   task print_verdict;
      begin
         if (miscompares == 0 && comparisons > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   task wr_reg(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk); addr <= a; wdata <= d; wr <= 1;
         @(posedge clk); wr <= 0;
      end
   endtask
   task rd_chk(input [7:0] a, input [7:0] e);
      begin
         @(posedge clk); addr <= a; rd <= 1;
         @(posedge clk); rd <= 0; #1;
         `CHK(rdata, e)
      end
   endtask
   // Counts word ticks until the applied volume lands on target
   task step_run(input [6:0] tgt, input integer steps, input integer m);
      begin
         n = 0; i = 0; #1;
         while (left_vol_applied !== tgt && i < 200) begin
            if (word_tick) n++;
            @(posedge clk); #1; i++;
         end
         if (left_vol_applied !== tgt) begin
            miscompares++;
            print_verdict;
         end else begin
            `CHK(n >= steps * m - m + 1 && n <= steps * m, 1'b1)
         end
      end
   endtask
   initial begin
      repeat (5) @(posedge clk);
      reset <= 0;
      rd_chk(8'h51, 8'h00);
      rd_chk(8'h52, 8'h88);
      `CHK({left_mute, right_mute}, 2'b11)
      for (i = 0; i < 3; i++) begin
         wr_reg(8'h51, {i[0], ~i[0], i[1:0], ~i[0], i[0], 2'h0});
         @(posedge clk); #1;
         `CHK({left_power, right_power, dmic_pin, left_dmic, right_dmic}, {i[0], ~i[0], i[1:0], ~i[0], i[0]})
      end
      for (i = 0; i < 5; i++) begin
         c = 3'(8 - i);
         wr_reg(8'h52, {i[0], c, ~i[0], c});
         @(posedge clk); #1;
         `CHK({left_mute, left_fine_atten, right_mute, right_fine_atten}, {i[0], c, ~i[0], c})
      end
      rd_chk(8'h52, 8'h4c);
      wr_reg(8'h52, 8'h9b);
      @(posedge clk); #1;
      `CHK({left_mute, left_fine_atten, right_mute, right_fine_atten}, 8'h88)
      wr_reg(8'h51, 8'h30);
      @(posedge clk); #1;
      `CHK(dmic_pin, 2'h0)
      wr_reg(8'h53, 8'h04);
      step_run(7'h04, 4, 1);
      wr_reg(8'h51, 8'h01);
      wr_reg(8'h53, 8'h00);
      step_run(7'h00, 4, 2);
      wr_reg(8'h51, 8'h02);
      wr_reg(8'h53, 8'h10);
      wr_reg(8'h54, 8'h10);
      @(posedge clk); #1;
      `CHK({left_vol_applied, right_vol_applied}, {2{7'h10}})
      wr_reg(8'h53, 8'h68);
      @(posedge clk); #1;
      `CHK(left_vol_applied, 7'h68)
      wr_reg(8'h51, 8'h00);
      wr_reg(8'h53, 8'h30);
      rd_chk(8'h53, 8'h28);
      rd_chk(8'h60, 8'h01);
      @(posedge clk); ce <= 1'b0;
      wr_reg(8'h51, 8'hc0);
      @(posedge clk); #1;
      `CHK(left_power, 1'b0)
      @(posedge clk); ce <= 1'b1;
      rd_chk(8'h51, 8'h00);
      print_verdict;
   end
endmodule
bind acsg_top acsg_top_assertions acsg_top_assertions_inst (.clk, .ce,
   .reset, .addr, .wdata, .wr, .left_power, .right_power, .dmic_pin,
   .left_dmic, .right_dmic, .left_mute, .right_mute, .left_fine_atten,
   .right_fine_atten, .left_vol_applied);
